// file: verilog/svwd_supervisor.sv
/*
  Supervisor core of a regulator: reset generator, plain and windowed
  watchdog, regulator hold latch, power-fail flag and APB registers.
  Assumes pins arrive asynchronously; supply_ok and power_fail_sense are
  digital comparator results; APB runs on sys_clk.
*/
// Register access over APB and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`include "svwd_map.svh"
module svwd_supervisor #(
  parameter int TMR_W = 24,
  parameter int WD_FIXED_TICKS = `SVWD_WD_FIXED_TICKS,
  parameter int RST_FIXED_TICKS = `SVWD_RST_FIXED_TICKS,
  parameter int TICK_CYCLES = `SVWD_TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_ok,
  input wire logic kick_input,
  input wire logic window_sel_lo,
  input wire logic window_sel_hi,
  input wire logic kick_monitor_off,
  input wire logic primary_turn_on,
  input wire logic hold_n,
  input wire logic power_fail_sense,
  input wire logic wd_period_select,
  input wire logic rst_period_select,
  output logic reset_n,
  output logic primary_supply_output,
  output logic power_fail_flag_n
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  if (TMR_W < 8 || TMR_W > 32) begin : g_chk_w
    $error("svwd_supervisor: TMR_W must be 8..32");
  end
  if (WD_FIXED_TICKS < 2 * `SVWD_FAST_MIN_TICKS ||
      longint'(WD_FIXED_TICKS) >= (64'd1 << TMR_W)) begin : g_chk_wd
    $error("svwd_supervisor: WD_FIXED_TICKS does not fit");
  end
  if (RST_FIXED_TICKS < 1 ||
      longint'(RST_FIXED_TICKS) >= (64'd1 << TMR_W)) begin : g_chk_rst
    $error("svwd_supervisor: RST_FIXED_TICKS does not fit");
  end

  localparam logic [TMR_W-1:0] WD_FIX = TMR_W'(WD_FIXED_TICKS);
  localparam logic [TMR_W-1:0] RST_FIX = TMR_W'(RST_FIXED_TICKS);
  localparam logic [TMR_W-1:0] FAST_MIN = TMR_W'(`SVWD_FAST_MIN_TICKS);
  localparam logic [TMR_W-1:0] CNT_ONE = TMR_W'(1);

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    svwd_pkg::svwd_state_t state;
    logic [TMR_W-1:0] rstCnt;
    logic [TMR_W-1:0] wdCnt;
    logic kickPrev;
    logic resetN;
    logic regOn;
    logic pfN;
    logic windowed;
    logic [TMR_W-1:0] adjWd;
    logic [TMR_W-1:0] adjRst;
    logic [31:0] rdData;
    logic slvErr;
  } svwd_core_t;

  svwd_core_t q;
  svwd_core_t n;

  logic [`SVWD_PIN_W-1:0] pinRaw;
  logic [`SVWD_PIN_W-1:0] pinSync;
  logic kickSync;
  logic selLo;
  logic selHi;
  logic monOff;
  logic turnOn;
  logic holdN;
  logic pfSense;
  logic wdFixSel;
  logic rstFixSel;
  logic supOk;
  logic tick;
  logic kickEdge;
  logic wdOff;
  logic wdFault;
  logic [TMR_W-1:0] slowLim;
  logic [TMR_W-1:0] fastRaw;
  logic [TMR_W-1:0] fastLim;
  logic [TMR_W-1:0] rstLim;
  logic [31:0] statusWord;

  // ----------------------------------------
  // pin synchronisers and time base
  // ----------------------------------------
  // pin bundle, hold idles high when unused
  assign pinRaw = {supply_ok, rst_period_select, wd_period_select, power_fail_sense,
                   hold_n, primary_turn_on, kick_monitor_off, window_sel_hi,
                   window_sel_lo, kick_input};

  svwd_sync #(
    .W(`SVWD_PIN_W),
    .RST_VAL(`SVWD_PIN_RST)
  ) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .din(pinRaw),
    .dout(pinSync)
  );

  svwd_tick_if tickBus ();

  svwd_timebase #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timebase (
    .sys_clk(sys_clk),
    .reset(reset),
    .tb(tickBus)
  );

  // unpack synchronised pins
  assign kickSync = pinSync[`SVWD_PIN_KICK];
  assign selLo = pinSync[`SVWD_PIN_SELLO];
  assign selHi = pinSync[`SVWD_PIN_SELHI];
  assign monOff = pinSync[`SVWD_PIN_MONOFF];
  assign turnOn = pinSync[`SVWD_PIN_TURNON];
  assign holdN = pinSync[`SVWD_PIN_HOLDN];
  assign pfSense = pinSync[`SVWD_PIN_PFS];
  assign wdFixSel = pinSync[`SVWD_PIN_WDSEL];
  assign rstFixSel = pinSync[`SVWD_PIN_RSTSEL];
  assign supOk = pinSync[`SVWD_PIN_SUPOK];
  assign tick = tickBus.tick;

  // ----------------------------------------
  // timeout selection
  // ----------------------------------------
  // straps: high picks the fixed timeouts
  assign slowLim = wdFixSel ? WD_FIX : q.adjWd;
  assign rstLim = rstFixSel ? RST_FIX : q.adjRst;

  // window ratio decode, one code switches off
  always_comb begin
    fastRaw = slowLim >> 3;
    case ({selHi, selLo})
      2'h0: fastRaw = slowLim >> 3;
      2'h2: fastRaw = slowLim >> 4;
      2'h3: fastRaw = slowLim >> 6;
      default: fastRaw = '0;
    endcase
  end

  // fast limit floor
  assign fastLim = (fastRaw < FAST_MIN) ? FAST_MIN : fastRaw;

  // watchdog off: window pins or single disable pin
  assign wdOff = q.windowed ? (selLo & ~selHi) : ~monOff;

  assign kickEdge = kickSync ^ q.kickPrev;

  // ----------------------------------------
  // watchdog fault detection
  // ----------------------------------------
  // plain mode: missed kick; window mode: early or late kick
  always_comb begin
    wdFault = 1'b0;
    if (q.resetN && !wdOff) begin
      if (!q.windowed) begin
        wdFault = !kickEdge && (q.wdCnt >= slowLim);
      end else if (kickEdge) begin
        wdFault = q.wdCnt < fastLim;
      end else begin
        wdFault = q.wdCnt >= slowLim;
      end
    end
  end

  // ----------------------------------------
  // status word
  // ----------------------------------------
  always_comb begin
    statusWord = '0;
    statusWord[`SVWD_STS_RESETN] = q.resetN;
    statusWord[`SVWD_STS_REGON] = q.regOn;
    statusWord[`SVWD_STS_PFN] = q.pfN;
    statusWord[`SVWD_STS_WDOFF] = wdOff;
    statusWord[`SVWD_STS_STATE +: 3] = q.state;
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n = q;
    n.kickPrev = kickSync;

    // apb setup phase: decode and latch read data
    if (psel && !penable) begin
      n.rdData = '0;
      n.slvErr = 1'b0;
      case (paddr)
        `SVWD_OFF_CTRL: n.rdData[`SVWD_CTRL_WINDOWED] = q.windowed;
        `SVWD_OFF_ADJWD: n.rdData[TMR_W-1:0] = q.adjWd;
        `SVWD_OFF_ADJRST: n.rdData[TMR_W-1:0] = q.adjRst;
        `SVWD_OFF_STATUS: n.rdData = statusWord;
        `SVWD_OFF_WDCNT: n.rdData[TMR_W-1:0] = q.wdCnt;
        default: n.slvErr = 1'b1;
      endcase
    end

    // apb access phase: writes land here
    if (psel && penable && pwrite && !q.slvErr) begin
      case (paddr)
        `SVWD_OFF_CTRL: n.windowed = pwdata[`SVWD_CTRL_WINDOWED];
        `SVWD_OFF_ADJWD: n.adjWd = pwdata[TMR_W-1:0];
        `SVWD_OFF_ADJRST: n.adjRst = pwdata[TMR_W-1:0];
        default: n.windowed = q.windowed;
      endcase
    end

    // reset sequencer
    case (q.state)
      svwd_pkg::ST_UV: begin
        n.rstCnt = '0;
        if (supOk) begin
          n.state = svwd_pkg::ST_TMO;
        end
      end
      svwd_pkg::ST_TMO: begin
        if (q.rstCnt >= rstLim) begin
          n.state = svwd_pkg::ST_RUN;
          n.rstCnt = '0;
        end else if (tick) begin
          n.rstCnt = q.rstCnt + CNT_ONE;
        end
      end
      svwd_pkg::ST_RUN: begin
        n.rstCnt = '0;
        if (wdFault) begin
          n.state = svwd_pkg::ST_TMO;
        end
      end
      default: begin
        n.state = svwd_pkg::ST_UV;
        n.rstCnt = '0;
      end
    endcase

    // undervoltage overrides every sequencer state
    if (!supOk) begin
      n.state = svwd_pkg::ST_UV;
      n.rstCnt = '0;
    end
    n.resetN = (n.state == svwd_pkg::ST_RUN);

    // watchdog counter
    if (!q.resetN || wdOff) begin
      n.wdCnt = '0;
    end else if (kickEdge && !wdFault) begin
      n.wdCnt = '0;
    end else if (tick && q.wdCnt < slowLim) begin
      n.wdCnt = q.wdCnt + CNT_ONE;
    end

    // regulator latch: enable turns on, hold keeps it on
    n.regOn = turnOn | (q.regOn & ~holdN);

    // power-fail flag follows comparator
    n.pfN = pfSense;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q.state <= svwd_pkg::ST_UV;
      q.rstCnt <= '0;
      q.wdCnt <= '0;
      q.kickPrev <= 1'b0;
      q.resetN <= 1'b0;
      q.regOn <= 1'b0;
      q.pfN <= 1'b0;
      q.windowed <= `SVWD_CTRL_RST;
      q.adjWd <= WD_FIX;
      q.adjRst <= RST_FIX;
      q.rdData <= '0;
      q.slvErr <= 1'b0;
    end else begin
      q <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reset_n = q.resetN;
  assign primary_supply_output = q.regOn;
  assign power_fail_flag_n = q.pfN;
  assign prdata = q.rdData;
  assign pslverr = q.slvErr & psel & penable;
  assign pready = 1'b1; // zero-wait slave
endmodule

// file: verilog/svwd_map.svh
/*
  Constants of the supervisor block: register offsets, field positions,
  reset values and timing counts. Assumes a 100 MHz sys_clk.
*/
`ifndef SVWD_MAP_SVH
`define SVWD_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SVWD_OFF_CTRL 8'h00
`define SVWD_OFF_ADJWD 8'h04
`define SVWD_OFF_ADJRST 8'h08
`define SVWD_OFF_STATUS 8'h0c
`define SVWD_OFF_WDCNT 8'h10

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define SVWD_CTRL_WINDOWED 0
`define SVWD_STS_RESETN 0
`define SVWD_STS_REGON 1
`define SVWD_STS_PFN 2
`define SVWD_STS_WDOFF 3
`define SVWD_STS_STATE 4
`define SVWD_CTRL_RST 1'b0
`define SVWD_PIN_KICK 0
`define SVWD_PIN_SELLO 1
`define SVWD_PIN_SELHI 2
`define SVWD_PIN_MONOFF 3
`define SVWD_PIN_TURNON 4
`define SVWD_PIN_HOLDN 5
`define SVWD_PIN_PFS 6
`define SVWD_PIN_WDSEL 7
`define SVWD_PIN_RSTSEL 8
`define SVWD_PIN_SUPOK 9
`define SVWD_PIN_W 10
`define SVWD_PIN_RST 10'h020

// ----------------------------------------
// timing
// ----------------------------------------
`define SVWD_CLK_MHZ 100
`define SVWD_TICK_NS 1000
`define SVWD_TICK_CYC ((`SVWD_TICK_NS * `SVWD_CLK_MHZ) / 1000)
`define SVWD_FAST_MIN_NS 2000
`define SVWD_FAST_MIN_TICKS ((`SVWD_FAST_MIN_NS + `SVWD_TICK_NS - 1) / `SVWD_TICK_NS)
`define SVWD_WD_FIXED_MS 400
`define SVWD_WD_FIXED_TICKS ((`SVWD_WD_FIXED_MS * 1000000) / `SVWD_TICK_NS)
`define SVWD_RST_FIXED_MS 100
`define SVWD_RST_FIXED_TICKS ((`SVWD_RST_FIXED_MS * 1000000) / `SVWD_TICK_NS)

`endif

// file: verilog/svwd_pkg.sv
/*
  Types of the supervisor block.
  Assumes the map header supplies all numeric constants.
*/
package svwd_pkg;

  // reset sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_UV = 3'h1,
    ST_TMO = 3'h2,
    ST_RUN = 3'h4
  } svwd_state_t;

endpackage

// file: verilog/svwd_tick_if.sv
/*
  Time-base tick carrier between the time base and the supervisor core.
  Assumes both ends run on sys_clk.
*/
`timescale 1ns/10ps
interface svwd_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface

// file: verilog/svwd_sync.sv
/*
  Two-stage synchroniser for a group of pin inputs.
  Assumes pins are asynchronous to sys_clk; RST_VAL is the idle pin level.
*/
`timescale 1ns/10ps
module svwd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } svwd_sync_t;

  svwd_sync_t q;
  svwd_sync_t n;

  if (W < 1) begin : g_chk
    $error("svwd_sync: W must be at least 1");
  end

  // first stage feeds only the second
  always_comb begin
    n = q;
    n.meta = din;
    n.stab = q.meta;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= {RST_VAL, RST_VAL};
    end else begin
      q <= n;
    end
  end

  assign dout = q.stab;
endmodule

// file: verilog/svwd_timebase.sv
/*
  Internal time base: one-cycle tick every TICK_CYCLES clocks.
  Assumes sys_clk free running.
*/
`timescale 1ns/10ps
`include "svwd_map.svh"
module svwd_timebase #(
  parameter int TICK_CYCLES = `SVWD_TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  svwd_tick_if.src tb
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } svwd_tb_t;

  svwd_tb_t q;
  svwd_tb_t n;

  if (TICK_CYCLES < 2 || TICK_CYCLES > 65536) begin : g_chk
    $error("svwd_timebase: TICK_CYCLES out of range");
  end

  // divider, tick on wrap
  always_comb begin
    n = q;
    n.tick = 1'b0;
    if (q.cnt == 16'(TICK_CYCLES - 1)) begin
      n.cnt = 16'h0000;
      n.tick = 1'b1;
    end else begin
      n.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tb.tick = q.tick;
endmodule

// file: test/svwd_cpu_model.sv
/*
  Processor model that toggles the watchdog kick pin.
  Assumes reset_n comes from the supervisor and sys_clk is shared.
*/
`timescale 1ns/10ps
module svwd_cpu_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic kickOn,
  input wire logic [15:0] kickPeriod,
  output logic kick_input
);
  logic [15:0] count_ff;
  logic kick_ff;
  initial count_ff = '0;
  initial kick_ff = 1'b0;
  assign kick_input = kick_ff;
  // toggle once per period, restart while held in reset
  always @(posedge sys_clk) begin
    if (!reset_n || !kickOn) begin
      count_ff <= '0;
    end else if (count_ff == kickPeriod - 16'h0001) begin
      count_ff <= '0;
      kick_ff <= ~kick_ff;
    end else begin
      count_ff <= count_ff + 16'h0001;
    end
  end
endmodule

// file: test/svwd_checker_assertions.sv
/*
  Concurrent checks on the supervisor ports.
  Assumes pin to output latency of three sys_clk edges.
*/
`timescale 1ns/10ps
module svwd_checker (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic supply_ok,
  input wire logic primary_turn_on,
  input wire logic hold_n,
  input wire logic power_fail_sense,
  input wire logic reset_n,
  input wire logic primary_supply_output,
  input wire logic power_fail_flag_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // reset output
  // ----------------------------------------
  uv_low_a: assert property (!supply_ok[*4] |-> !reset_n)
    else $error("reset out high in undervoltage");
  rel_ok_a: assert property ($rose(reset_n) |-> $past(supply_ok, 12))
    else $error("reset released too soon");
  rst_hold_a: assert property ($rose(supply_ok) |-> !reset_n[*8])
    else $error("no reset timeout");
  pulse_len_a: assert property ($fell(reset_n) |=> !reset_n[*8])
    else $error("reset pulse too short");
  // ----------------------------------------
  // flag and regulator
  // ----------------------------------------
  pf_hi_a: assert property (power_fail_sense[*4] |-> power_fail_flag_n)
    else $error("flag low with sense high");
  pf_lo_a: assert property (!power_fail_sense[*4] |-> !power_fail_flag_n)
    else $error("flag high with sense low");
  reg_on_a: assert property (primary_turn_on[*4] |-> primary_supply_output)
    else $error("output off while enabled");
  reg_off_a: assert property ((!primary_turn_on && hold_n)[*4]
    |-> !primary_supply_output)
    else $error("output on without enable or hold");
  hold_keep_a: assert property (!hold_n[*4] ##0 primary_supply_output
    |=> primary_supply_output)
    else $error("hold lost output");
  hold_only_on_a: assert property (!primary_turn_on[*4] ##0 !primary_supply_output
    |=> !primary_supply_output)
    else $error("hold started output");
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  apb_err_a: assert property (psel && penable && paddr > 8'h10 |-> pslverr && pready)
    else $error("unmapped access not refused");
  apb_ok_a: assert property (psel && penable && paddr inside {8'h00, 8'h04, 8'h08, 8'h0c,
    8'h10} |-> !pslverr && pready)
    else $error("mapped access refused");
endmodule
bind svwd_supervisor svwd_checker svwd_checker_i (.sys_clk(sys_clk), .reset(reset),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .supply_ok(supply_ok), .primary_turn_on(primary_turn_on), .hold_n(hold_n),
  .power_fail_sense(power_fail_sense), .reset_n(reset_n),
  .primary_supply_output(primary_supply_output), .power_fail_flag_n(power_fail_flag_n));

// file: test/svwd_supervisor_tb_top.sv
/*
  Self-checking bench of the supervisor with a processor kick model.
  Assumes shortened counts: 4 cycle tick, 200 tick watchdog, 10 tick reset.
*/
`timescale 1ns/10ps
module svwd_supervisor_tb_top;
  localparam int TK = 4;
  logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, f, kick_input, reset_n, primary_supply_output, power_fail_flag_n;
  logic supply_ok = 0, window_sel_lo = 0, window_sel_hi = 0, kick_monitor_off = 1;
  logic primary_turn_on = 0, hold_n = 1, power_fail_sense = 0;
  logic wd_period_select = 1, rst_period_select = 1, kickOn = 0;
  logic [15:0] kickPeriod = '0;
  logic [17:0] tbl [7] = '{{2'h0, 16'h0040}, {2'h0, 16'h0078}, {2'h2, 16'h0020},
    {2'h2, 16'h0040}, {2'h3, 16'h0020}, {2'h1, 16'h0000}, {2'h0, 16'h0000}};
  logic expFault [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  int fail_count = 0, checked = 0, n;
  always #5 sys_clk = ~sys_clk;
  svwd_supervisor #(.WD_FIXED_TICKS(200), .RST_FIXED_TICKS(10), .TICK_CYCLES(TK))
    svwd_supervisor_i (
    .sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .supply_ok(supply_ok), .kick_input(kick_input), .window_sel_lo(window_sel_lo),
    .window_sel_hi(window_sel_hi), .kick_monitor_off(kick_monitor_off),
    .primary_turn_on(primary_turn_on), .hold_n(hold_n), .power_fail_sense(power_fail_sense),
    .wd_period_select(wd_period_select), .rst_period_select(rst_period_select),
    .reset_n(reset_n), .primary_supply_output(primary_supply_output),
    .power_fail_flag_n(power_fail_flag_n)
  );
  svwd_cpu_model svwd_cpu_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .kickOn(kickOn),
    .kickPeriod(kickPeriod), .kick_input(kick_input));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // count edges while reset output is low
  task automatic up();
    n = 0;
    while (reset_n !== 1'b1 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) fail_count++; // reset output never released
  endtask
  task automatic watch(input int lim);
    f = 0;
    repeat (lim) begin
      @(posedge sys_clk);
      if (reset_n !== 1'b1) f = 1;
    end
  endtask
  // let a pin change pass synchroniser and output register
  task automatic settle();
    repeat (5) @(posedge sys_clk);
  endtask
  task automatic report_and_stop();
    if (fail_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    chk("rst", {reset_n, primary_supply_output, power_fail_flag_n}, 3'h0);
    reset <= 0;
    apb(0, 8'h00, 32'h0);
    chk("ctrl", rd, 32'h0);
    apb(0, 8'h04, 32'h0);
    chk("adjwd", rd, 32'hc8);
    apb(0, 8'h08, 32'h0);
    chk("adjrst", rd, 32'ha);
    apb(0, 8'h14, 32'h0);
    chk("unmaperr", {31'h0, er}, 32'h1);
    chk("unmaprd", rd, 32'h0);
    apb(0, 8'h0c, 32'h0);
    chk("state", rd[6:4], 3'h1);
    settle();
    chk("uvlow", reset_n, 1'b0);
    supply_ok <= 1;
    up();
    chk("rstlen", n >= 40 && n <= 56, 1'b1);
    power_fail_sense <= 1;
    settle();
    chk("pfhi", power_fail_flag_n, 1'b1);
    power_fail_sense <= 0;
    settle();
    chk("pflo", power_fail_flag_n, 1'b0);
    hold_n <= 0;
    settle();
    chk("hoff", primary_supply_output, 1'b0);
    primary_turn_on <= 1;
    settle();
    chk("on", primary_supply_output, 1'b1);
    primary_turn_on <= 0;
    settle();
    chk("held", primary_supply_output, 1'b1);
    hold_n <= 1;
    settle();
    chk("off", primary_supply_output, 1'b0);
    primary_turn_on <= 1;
    settle();
    chk("on2", primary_supply_output, 1'b1);
    primary_turn_on <= 0;
    settle();
    chk("unused", primary_supply_output, 1'b0);
    kickPeriod <= 16'h0040;
    kickOn <= 1;
    watch(1000);
    chk("kicked", f, 1'b0);
    kickOn <= 0;
    watch(1000);
    chk("starved", f, 1'b1);
    up();
    kick_monitor_off <= 0;
    watch(1000);
    chk("dis", f, 1'b0);
    kick_monitor_off <= 1;
    wd_period_select <= 0;
    apb(1, 8'h04, 32'h14);
    up();
    watch(150);
    chk("adjwd1", f, 1'b1);
    up();
    watch(150);
    chk("adjwd2", f, 1'b1);
    wd_period_select <= 1;
    rst_period_select <= 0;
    apb(1, 8'h08, 32'h3);
    up();
    supply_ok <= 0;
    repeat (6) @(posedge sys_clk);
    apb(0, 8'h10, 32'h0);
    chk("cnt", rd, 32'h0);
    supply_ok <= 1;
    up();
    chk("adjlen", n >= 12 && n <= 26, 1'b1);
    rst_period_select <= 1;
    apb(1, 8'h00, 32'h1);
    for (int i = 0; i < 7; i++) begin
      supply_ok <= 0;
      kickOn <= 0;
      repeat (6) @(posedge sys_clk);
      {window_sel_hi, window_sel_lo} <= tbl[i][17:16];
      kickPeriod <= tbl[i][15:0];
      supply_ok <= 1;
      up();
      kickOn <= (tbl[i][15:0] != 16'h0000);
      watch(900);
      chk("window", f, expFault[i]);
    end
    // short adjusted timeout: only the floor makes one-tick kicks early
    supply_ok <= 0;
    kickOn <= 0;
    wd_period_select <= 0;
    repeat (6) @(posedge sys_clk);
    {window_sel_hi, window_sel_lo} <= 2'h3;
    kickPeriod <= 16'h0004;
    supply_ok <= 1;
    up();
    kickOn <= 1;
    watch(200);
    chk("floor", f, 1'b1);
    report_and_stop();
  end
  // hang guard, well beyond the expected run
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
endmodule
